/* File: inc/dse_pkg.sv */
package dse_pkg;
  // raw input word width and symbol limits
  localparam int DATA_W = 8;
  localparam int MAX_BITS = 4;
  localparam int MAX_STATES = 16;
  localparam int OFF_W = 8;
  localparam int FIFO_DEPTH = 16;
  // values after reset
  localparam logic [3:0] RST_STATE = 4'h0;
  localparam logic [4:0] RST_NSTATES = 5'h04;
  localparam logic [2:0] RST_BPS = 3'h2;
  localparam logic RST_PREV_BIT = 1'b0;

  // encoder mode: symbol offset walk or bit level xor
  typedef enum logic {
    DSE_MODE_OFFSET = 1'b0,
    DSE_MODE_BITDIFF = 1'b1
  } dse_mode_e;

  // run state: encoding waits for a defined starting state
  typedef enum logic [1:0] {
    DSE_IDLE = 2'b00,
    DSE_RUN = 2'b01
  } dse_run_e;

  // word carried through the input fifo
  typedef struct packed {
    logic [DATA_W-1:0] data;
  } dse_word_s;

  // encoded output word
  typedef struct packed {
    logic [3:0] stateIdx;
    logic iNeg;
    logic qNeg;
    logic encBit;
  } dse_out_s;

  // ceiling of log2, never below one bit nor above four
  function automatic logic [2:0] dse_ceil_log2(input logic [4:0] n);
    logic [2:0] r;
    r = 3'h1;
    if (n > 5'h02) r = 3'h2;
    if (n > 5'h04) r = 3'h3;
    if (n > 5'h08) r = 3'h4;
    return r;
  endfunction : dse_ceil_log2
endpackage : dse_pkg

/* File: src/dse_fifo.sv */
`timescale 1ns/1ps
module dse_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // storage words
  logic [AW:0] wrPtr; // write pointer with wrap bit
  logic [AW:0] rdPtr; // read pointer with wrap bit
  logic memEmpty;
  logic memFull;
  logic push;
  logic pull;
  logic [AW:0] wrNext; // write pointer after this cycle
  logic [AW:0] rdNext; // read pointer after this cycle

  // full and empty from pointer compare
  assign memEmpty = (wrPtr == rdPtr);
  assign memFull = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign wrNext = wrPtr + {{AW{1'b0}}, push};
  assign rdNext = rdPtr + {{AW{1'b0}}, pull};

  // registered ready: not full after this cycle's push and pull
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inReady <= 1'b1;
    end else begin
      inReady <= !((wrNext[AW] != rdNext[AW]) && (wrNext[AW-1:0] == rdNext[AW-1:0]));
    end
  end
  assign push = inValid && !memFull;
  // refill the head register when empty or being drained
  assign pull = !memEmpty && (!outValid || outReady);

  // write side
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  // write pointer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
    end else if (push) begin
      wrPtr <= wrPtr + 1'b1;
    end
  end

  // read pointer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdPtr <= '0;
    end else if (pull) begin
      rdPtr <= rdPtr + 1'b1;
    end
  end

  // registered head word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      outValid <= 1'b0;
      outData <= '0;
    end else if (pull) begin
      outValid <= 1'b1;
      outData <= mem[rdPtr[AW-1:0]];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end
endmodule : dse_fifo

/* File: src/dse_encoder.sv */
// Overview of operation
// RULE1: bits per symbol is ceiling log2 of states
// RULE2: each symbol looks up offset, moves state
// RULE3: plus one advances one state forward
// RULE4: negative moves backward, zero holds state
// RULE5: table holds one signed offset per value
// RULE6: state starts from a loaded starting state
// RULE7: data picks transition, never absolute location
// RULE8: same data value gives same transition
// RULE9: two bits split stream into 2-bit symbols
// RULE10: one bit uses only the lsb
// RULE11: default four state map uses plus/minus one
// RULE12: applies to any user i/q or fsk map
// RULE13: only on real time paths, not arb
// RULE14: bit encoding acts before i/q mapping
// RULE15: change emits one, no change emits zero
// RULE16: output bit is previous xor current bit
// RULE17: state index wraps modulo map size
// RULE18: one symbol per valid, else state held
`timescale 1ns/1ps
module dse_encoder
  import dse_pkg::*;
#(
  parameter int DATA_WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic inValid,
  input wire logic [DATA_WIDTH-1:0] inData,
  output logic inReady,
  input wire logic [4:0] numStates,
  input wire logic modeSel,
  input wire logic diffEnable,
  input wire logic pathRealtime,
  input wire logic [3:0] startState,
  input wire logic startLoad,
  input wire logic tblWrEn,
  input wire logic [3:0] tblWrAddr,
  input wire logic signed [OFF_W-1:0] tblWrData,
  output logic outValid,
  output dse_out_s outWord,
  input wire logic outReady,
  output logic [2:0] bitsPerSym
);
  logic rstMeta; // first reset stage
  logic rstn; // released reset copy
  logic [4:0] numStatesReg; // map size, clamped to one or more
  logic signed [OFF_W-1:0] offTable [MAX_STATES]; // offset per data value
  dse_run_e runState; // idle until a start state is loaded
  dse_mode_e mode; // mode decoded from the select input
  logic [3:0] stateIdx; // current state map index
  logic prevBit; // previous raw bit
  logic fifoValid; // head word present
  dse_word_s fifoWord; // head word
  dse_word_s inWord; // input word packed
  logic take; // consume one symbol this cycle
  logic canAdvance; // output slot free or draining
  logic [7:0] symMask; // mask of significant data bits
  logic [DATA_WIDTH-1:0] sym; // masked data symbol
  logic [3:0] tblIdx; // table index from the symbol
  logic signed [OFF_W-1:0] offSel; // offset looked up
  logic signed [9:0] nStatesS; // map size as signed
  logic signed [9:0] offMod; // offset reduced into the map
  logic signed [9:0] sumW; // wrapped sum
  logic [3:0] next_stateIdx; // state after this symbol
  logic encActive; // differential encoding in force
  logic rawBit; // raw bit of the head word
  logic next_encBit; // encoded bit

  // two stage reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstn <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstn <= rstMeta;
    end
  end

  assign inWord.data = inData;
  assign mode = dse_mode_e'(modeSel);

  // input fifo in the data path
  dse_fifo #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .inValid(inValid),
    .inData(inWord),
    .inReady(inReady),
    .outValid(fifoValid),
    .outData(fifoWord),
    .outReady(take)
  );

  // map size and symbol width register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      numStatesReg <= RST_NSTATES;
      bitsPerSym <= RST_BPS;
    end else begin
      numStatesReg <= (numStates == 5'h00) ? 5'h01 :
                      (numStates > 5'h10) ? 5'h10 : numStates;
      bitsPerSym <= dse_ceil_log2(numStates); // see RULE1
    end
  end

  // offset table, one signed entry per data value
  for (genvar g = 0; g < MAX_STATES; g++) begin : g_tbl
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        offTable[g] <= '0;
      end else if (tblWrEn && (tblWrAddr == 4'(g))) begin
        offTable[g] <= tblWrData; // see RULE5
      end
    end
  end

  // slot free when empty or when the sink takes the word
  assign canAdvance = !outValid || outReady;
  // a start load wins over a symbol in the same cycle
  assign take = fifoValid && canAdvance && !startLoad && (runState == DSE_RUN); // see RULE18

  // keep only the low bitsPerSym bits of the data value
  assign symMask = 8'((9'h001 << bitsPerSym) - 9'h001); // see RULE9
  assign sym = fifoWord.data & DATA_WIDTH'(symMask); // see RULE10
  assign tblIdx = sym[3:0];
  // offset depends on the value only, not on position
  assign offSel = offTable[tblIdx]; // see RULE8
  assign encActive = diffEnable && pathRealtime; // see RULE13
  assign rawBit = fifoWord.data[0];

  // signed move through the map with wrap
  always_comb begin
    nStatesS = {5'h00, numStatesReg};
    offMod = 10'(offSel) % nStatesS;
    if (offMod < 0) begin
      offMod = offMod + nStatesS; // see RULE4
    end
    sumW = {6'h00, stateIdx} + offMod; // see RULE3
    if (sumW >= nStatesS) begin
      sumW = sumW - nStatesS; // see RULE17
    end
    if (encActive) begin
      next_stateIdx = sumW[3:0]; // see RULE2
    end else begin
      next_stateIdx = tblIdx;
    end
  end

  // bit level encoding ahead of mapping
  assign next_encBit = encActive ? (prevBit ^ rawBit) : rawBit; // see RULE16

  // run state: wait for a start state before encoding
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      runState <= DSE_IDLE;
    end else begin
      case (runState)
        DSE_IDLE: begin
          if (startLoad) begin
            runState <= DSE_RUN; // see RULE6
          end
        end
        DSE_RUN: begin
          runState <= DSE_RUN;
        end
        default: begin
          runState <= DSE_IDLE;
        end
      endcase
    end
  end

  // state index: startState on a start load, relative move per offset symbol while encoding is active, the symbol value when not, held otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stateIdx <= RST_STATE;
    end else if (startLoad) begin
      stateIdx <= startState; // see RULE6
    end else if (take && (mode == DSE_MODE_OFFSET)) begin
      stateIdx <= next_stateIdx; // see RULE7
    end
  end

  // previous raw bit register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prevBit <= RST_PREV_BIT;
    end else if (startLoad) begin
      prevBit <= RST_PREV_BIT;
    end else if (take && (mode == DSE_MODE_BITDIFF)) begin
      prevBit <= rawBit; // see RULE14
    end
  end

  // output register with back pressure
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      outValid <= 1'b0;
      outWord <= '0;
    end else if (take) begin
      outValid <= 1'b1;
      if (mode == DSE_MODE_OFFSET) begin
        // default four state map: 0 ++, 1 -+, 2 --, 3 +-
        outWord.stateIdx <= next_stateIdx; // see RULE12
        outWord.iNeg <= next_stateIdx[0] ^ next_stateIdx[1]; // see RULE11
        outWord.qNeg <= next_stateIdx[1];
        outWord.encBit <= 1'b0;
      end else begin
        outWord.stateIdx <= stateIdx;
        outWord.iNeg <= 1'b0;
        outWord.qNeg <= 1'b0;
        outWord.encBit <= next_encBit; // see RULE15
      end
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end

  // reference wrap used only by the checks
  function automatic logic [3:0] refMove(input logic [3:0] s,
                                         input logic signed [OFF_W-1:0] o,
                                         input logic [4:0] n);
    int t;
    t = (int'(s) + int'(o) + 16 * int'(n) * 16) % int'(n);
    return 4'(t);
  endfunction : refMove

  logic checkOffset; // offset walk symbol taken
  logic checkBit; // bit symbol taken
  assign checkOffset = take && (mode == DSE_MODE_OFFSET);
  assign checkBit = take && (mode == DSE_MODE_BITDIFF);

  sequence s_taken;
    checkOffset && encActive;
  endsequence

  sequence s_landed(logic [3:0] expIdx);
    outValid && (outWord.stateIdx == expIdx) && (stateIdx == expIdx);
  endsequence

  property p_bps;
    @(posedge clk) disable iff (!rstn)
      $stable(numStates) |=> (bitsPerSym == dse_ceil_log2($past(numStates)));
  endproperty
  a_bps: assert property (p_bps) else $error("bits per symbol wrong"); // see RULE1

  property p_move;
    @(posedge clk) disable iff (!rstn)
      s_taken |=> s_landed(refMove($past(stateIdx), $past(offSel), $past(numStatesReg)));
  endproperty
  a_move: assert property (p_move) else $error("offset move wrong"); // see RULE2

  property p_plus_one;
    @(posedge clk) disable iff (!rstn)
      s_taken and (offSel == 8'sh01) and (numStatesReg == 5'h04)
      |=> (stateIdx == 4'($past(stateIdx) + 4'h1) % 4'h4);
  endproperty
  a_plus_one: assert property (p_plus_one) else $error("plus one not forward"); // see RULE3

  property p_zero;
    @(posedge clk) disable iff (!rstn)
      s_taken and (offSel == 8'sh00) |=> $stable(stateIdx);
  endproperty
  a_zero: assert property (p_zero) else $error("zero offset moved"); // see RULE4

  property p_hold;
    @(posedge clk) disable iff (!rstn)
      !take && !startLoad |=> $stable(stateIdx) && $stable(prevBit);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved without symbol"); // see RULE18

  property p_init;
    @(posedge clk) disable iff (!rstn)
      startLoad |=> (stateIdx == $past(startState)) && (runState == DSE_RUN)
                    && (outValid == ($past(outValid) && !$past(outReady)));
  endproperty
  a_init: assert property (p_init) else $error("start state not loaded"); // see RULE6

  property p_xor;
    @(posedge clk) disable iff (!rstn)
      checkBit && encActive |=> outValid && (outWord.encBit == ($past(prevBit) ^ $past(rawBit)));
  endproperty
  a_xor: assert property (p_xor) else $error("encoded bit not xor"); // see RULE16

  property p_map;
    @(posedge clk) disable iff (!rstn)
      checkOffset |=> (outWord.iNeg == (outWord.stateIdx[0] ^ outWord.stateIdx[1]))
                      && (outWord.qNeg == outWord.stateIdx[1]);
  endproperty
  a_map: assert property (p_map) else $error("default map sign wrong"); // see RULE11

  property p_arb;
    @(posedge clk) disable iff (!rstn)
      checkOffset && !pathRealtime |=> (outWord.stateIdx == $past(tblIdx));
  endproperty
  a_arb: assert property (p_arb) else $error("encoding on arb path"); // see RULE13

  property p_lsb;
    @(posedge clk) disable iff (!rstn)
      fifoValid && (bitsPerSym == 3'h1) |-> (offSel == offTable[{3'h0, fifoWord.data[0]}]);
  endproperty
  a_lsb: assert property (p_lsb) else $error("upper bits used at one bit"); // see RULE10

  property p_stall;
    @(posedge clk) disable iff (!rstn)
      outValid && !outReady |=> outValid && $stable(outWord);
  endproperty
  a_stall: assert property (p_stall) else $error("output dropped under stall"); // see RULE18
endmodule : dse_encoder

/* File: dv/dse_sink_model.sv */
`timescale 1ns/1ps
// far side sink: takes encoded words at a chosen pace
module dse_sink_model
  import dse_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [1:0] pace,
  output logic outReady
);
  logic [1:0] tick; // divider for the slow pace
  // pace 0 always ready, 1 one cycle in three, 2 stalled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick <= 2'h0;
      outReady <= 1'b0;
    end else begin
      tick <= (tick == 2'h2) ? 2'h0 : tick + 2'h1;
      outReady <= (pace == 2'h0) || (pace == 2'h1 && tick == 2'h0);
    end
  end
endmodule : dse_sink_model

/* File: dv/dse_encoder_test.sv */
`timescale 1ns/1ps
// self-checking bench for the encoder
module dse_encoder_test
  import dse_pkg::*;
;
  logic clk = 1'b0; // 200 MHz clock
  logic resetn = 1'b0; // active low reset
  logic inValid, startLoad, tblWrEn, modeSel, diffEnable, pathRealtime;
  logic inReady, outValid, outReady;
  logic [7:0] inData;
  logic [4:0] numStates;
  logic [3:0] startState, tblWrAddr;
  logic signed [OFF_W-1:0] tblWrData;
  logic [2:0] bitsPerSym;
  logic [1:0] pace; // sink pace
  dse_out_s outWord;
  dse_out_s rxq[$]; // words taken by the sink
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0; // cycles run, for the hang limit
  // one row: states, data word, expected state, expected bits per symbol
  typedef struct packed {logic [4:0] n; logic [7:0] d; logic [3:0] st; logic [2:0] bps;} dse_row_s;
  dse_row_s rows [12];

  always #2.5 clk = ~clk;

  dse_encoder #(.DATA_WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) dut (
    .clk(clk), .resetn(resetn), .inValid(inValid), .inData(inData), .inReady(inReady),
    .numStates(numStates), .modeSel(modeSel), .diffEnable(diffEnable),
    .pathRealtime(pathRealtime), .startState(startState), .startLoad(startLoad),
    .tblWrEn(tblWrEn), .tblWrAddr(tblWrAddr), .tblWrData(tblWrData), .outValid(outValid),
    .outWord(outWord), .outReady(outReady), .bitsPerSym(bitsPerSym));
  dse_sink_model sink (.clk(clk), .resetn(resetn), .pace(pace), .outReady(outReady));

  // capture every word the sink accepts
  always @(posedge clk) begin
    if (resetn && outValid === 1'b1 && outReady === 1'b1) rxq.push_back(outWord);
  end

  // hang limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chkVal(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chkVal

  // present a word, held until taken; ends at the falling edge after the take
  task automatic send(input logic [7:0] d);
    int k;
    inValid = 1'b1;
    inData = d;
    k = 0;
    while (inReady !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    inValid = 1'b0;
  endtask : send

  // wait, bounded, for one accepted word
  task automatic getOut(output dse_out_s w);
    int k;
    k = 0;
    while (rxq.size() == 0 && k < 200) begin
      @(negedge clk);
      k++;
    end
    chkVal("output present", 8'h01, {7'h0, rxq.size() > 0});
    w = (rxq.size() > 0) ? rxq.pop_front() : 'x;
  endtask : getOut

  // state of the next word, and its default map signs when numStates is four
  task automatic chkOut(input logic [3:0] st);
    dse_out_s w;
    logic [1:0] sg;
    getOut(w);
    chkVal("stateIdx", {4'h0, st}, {4'h0, w.stateIdx});
    // default map signs: 0 ++, 1 -+, 2 --, 3 +-
    sg = 2'(8'h78 >> {st, 1'b0});
    if (numStates == 5'h04) chkVal("iq signs", {6'h0, sg}, {6'h0, w.iNeg, w.qNeg});
  endtask : chkOut

  task automatic wrTbl(input logic [3:0] a, input logic [7:0] v);
    tblWrEn = 1'b1;
    tblWrAddr = a;
    tblWrData = v;
    @(negedge clk);
    tblWrEn = 1'b0;
    @(negedge clk);
  endtask : wrTbl

  task automatic loadStart(input logic [3:0] s);
    startState = s;
    startLoad = 1'b1;
    @(negedge clk);
    startLoad = 1'b0;
    @(negedge clk);
  endtask : loadStart

  // main sequence
  initial begin
    int acc;
    logic [13:0] raw;
    logic prev;
    dse_out_s w;
    rows = '{'{5'h04, 8'h00, 4'h1, 3'h2}, '{5'h04, 8'h03, 4'h1, 3'h2},
      '{5'h04, 8'h02, 4'h3, 3'h2}, '{5'h04, 8'h00, 4'h0, 3'h2},
      '{5'h04, 8'h01, 4'h3, 3'h2}, '{5'h08, 8'h02, 4'h5, 3'h3},
      '{5'h09, 8'h10, 4'h6, 3'h4}, '{5'h10, 8'h01, 4'h5, 3'h4},
      '{5'h10, 8'h03, 4'h5, 3'h4}, '{5'h07, 8'h00, 4'h6, 3'h3},
      '{5'h08, 8'h00, 4'h7, 3'h3}, '{5'h08, 8'h00, 4'h0, 3'h3}};
    inValid = 1'b0;
    inData = 8'h00;
    startLoad = 1'b0;
    startState = 4'h0;
    tblWrEn = 1'b0;
    tblWrAddr = 4'h0;
    tblWrData = 8'h00;
    modeSel = 1'b0;
    diffEnable = 1'b1;
    pathRealtime = 1'b1;
    numStates = 5'h04;
    pace = 2'h0;
    repeat (16) @(negedge clk);
    chkVal("outValid", 8'h00, {7'h0, outValid});
    chkVal("bitsPerSym", 8'h02, {5'h0, bitsPerSym});
    chkVal("inReady", 8'h01, {7'h0, inReady});
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    wrTbl(4'h0, 8'h01);
    wrTbl(4'h1, 8'hff);
    wrTbl(4'h2, 8'h02);
    wrTbl(4'h3, 8'h00);
    // nothing leaves before a starting state is loaded
    send(8'h03);
    repeat (10) @(negedge clk);
    chkVal("idle outValid", 8'h00, {7'h0, outValid});
    loadStart(4'h0);
    chkOut(4'h0);
    foreach (rows[i]) begin
      numStates = rows[i].n;
      send(rows[i].d);
      chkOut(rows[i].st);
      chkVal("bitsPerSym", {5'h0, rows[i].bps}, {5'h0, bitsPerSym});
    end
    // other starting state
    numStates = 5'h04;
    loadStart(4'h2);
    send(8'h00);
    chkOut(4'h3);
    // playback path and encoding off give the absolute symbol
    pathRealtime = 1'b0;
    send(8'h02);
    chkOut(4'h2);
    pathRealtime = 1'b1;
    diffEnable = 1'b0;
    send(8'h01);
    chkOut(4'h1);
    diffEnable = 1'b1;
    // one bit per symbol: only the lsb selects
    numStates = 5'h02;
    loadStart(4'h0);
    send(8'hfe);
    chkOut(4'h1);
    send(8'h03);
    chkOut(4'h0);
    chkVal("bitsPerSym", 8'h01, {5'h0, bitsPerSym});
    // bit level xor stream
    modeSel = 1'b1;
    loadStart(4'h0);
    raw = 14'b01010011001010;
    prev = 1'b0;
    for (int b = 13; b >= 0; b--) begin
      send({7'h0, raw[b]});
      getOut(w);
      chkVal("encBit", {7'h0, raw[b] ^ prev}, {7'h0, w.encBit});
      prev = raw[b];
    end
    // encoding off in bit mode passes the raw bit, even after a one
    diffEnable = 1'b0;
    repeat (2) begin
      send(8'h01);
      getOut(w);
      chkVal("raw bit", 8'h01, {7'h0, w.encBit});
    end
    diffEnable = 1'b1;
    // fill against a stalled sink, then drain slowly
    modeSel = 1'b0;
    numStates = 5'h04;
    pace = 2'h2;
    loadStart(4'h1);
    acc = 0;
    inValid = 1'b1;
    inData = 8'h03;
    repeat (30) begin
      if (inReady === 1'b1) acc++;
      @(negedge clk);
    end
    inValid = 1'b0;
    chkVal("inReady full", 8'h00, {7'h0, inReady});
    chkVal("words held", 8'h01, {7'h0, acc >= FIFO_DEPTH});
    pace = 2'h1;
    repeat (acc) chkOut(4'h1);
    repeat (10) @(negedge clk);
    chkVal("extra words", 8'h00, 8'(rxq.size()));
    tally_and_finish();
  end
endmodule : dse_encoder_test
